// ===== logic/emb_bus_out.sv
// External bus and port outputs of the emulation pod, with AHB-Lite registers.
// Assumes core inputs and pins are synchronous to core_clk and one AHB-Lite master.
//
// The address map and register access over AHB-Lite were decided locally.
`timescale 1ns/100ps
`include "emb_params.svh"
module emb_bus_out #(
   parameter int ADDR_W = 20,
   parameter int DATA_W = 16
) (
   input  wire logic                  core_clk,
   input  wire logic                  reset,
   input  wire logic                  ce,
   // AHB-Lite slave
   input  wire logic                  hsel,
   input  wire logic [31:0]           haddr,
   input  wire logic [1:0]            htrans,
   input  wire logic                  hwrite,
   input  wire logic [2:0]            hsize,
   input  wire logic [31:0]           hwdata,
   input  wire logic                  hready,
   output logic                       hreadyout,
   output logic                       hresp,
   output logic [31:0]                hrdata,
   // Emulated core side
   input  wire emb_pkg::emb_mode_e    coreMode,
   input  wire logic                  accValid,
   input  wire emb_pkg::emb_area_e    accArea,
   input  wire logic                  accWrite,
   input  wire logic [ADDR_W-1:0]     accAddr,
   input  wire logic                  accByteHigh_n,
   input  wire logic [DATA_W-1:0]     accWdata,
   input  wire logic                  strobePhase,
   input  wire logic                  alePhase,
   input  wire logic                  busHalfTick,
   output logic [DATA_W-1:0]          readData,
   output logic                       readDataValid,
   output logic                       coreResetReq,
   // Target side bus
   output logic [ADDR_W-1:0]          addrOut,
   output logic                       byteHighEnable_n,
   output logic [DATA_W-1:0]          dataOut,
   output logic                       dataOe_n,
   input  wire logic [DATA_W-1:0]     dataIn,
   output logic                       readStrobe_n,
   output logic                       writeStrobe_n,
   output logic                       chipSelect_n,
   output logic                       addrLatchStrobe,
   output logic                       busOe_n,
   input  wire logic                  busHoldRequest_n,
   input  wire logic                  targetReset_n,
   // Ports
   output logic [10:0]                pullupDrive,
   output logic [7:0]                 port10Dir,
   input  wire logic [7:0]            port10Pins,
   output logic [7:0]                 port10PortData,
   output logic [7:0]                 port10KeyLevel
);

   // ----------------------------------------------------------------------
   // AHB-Lite address phase
   // ----------------------------------------------------------------------
   logic                  wrPend_reg;
   logic [7:0]            phAddr_reg;
   logic [10:0]           pullupCfg_reg;
   logic [7:0]            p10Dir_reg;
   emb_pkg::emb_adsel_e   adSel_reg;
   logic                  resetSeen_reg;
   logic                  holdActive;
   logic                  port10Blocked;
   logic                  misuse;

   always_ff @(posedge core_clk) begin
      if (reset) begin
         wrPend_reg <= 1'b0;
         phAddr_reg <= 8'h00;
      end else if (ce && hready) begin
         wrPend_reg <= hsel && htrans[1] && hwrite && hsize == 3'h2;
         phAddr_reg <= haddr[7:0];
      end
   end

   assign hreadyout = ce;
   assign hresp     = 1'b0;

   // ----------------------------------------------------------------------
   // Register writes
   // ----------------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (reset) begin
         pullupCfg_reg <= `EMB_PULLUP_RST;
      end else if (ce && wrPend_reg && phAddr_reg == `EMB_OFS_PULLUP) begin
         pullupCfg_reg <= hwdata[10:0];
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         p10Dir_reg <= `EMB_P10DIR_RST;
      end else if (ce && wrPend_reg && phAddr_reg == `EMB_OFS_P10DIR) begin
         p10Dir_reg <= hwdata[7:0];
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         adSel_reg <= emb_pkg::emb_adsel_e'(`EMB_ADSEL_RST);
      end else if (ce && wrPend_reg && phAddr_reg == `EMB_OFS_ADSEL) begin
         adSel_reg <= emb_pkg::emb_adsel_e'(hwdata[1:0]);
      end
   end

   // ----------------------------------------------------------------------
   // Register reads
   // ----------------------------------------------------------------------
   always_comb begin
      hrdata = 32'h0000_0000;
      unique case (phAddr_reg)
         `EMB_OFS_PULLUP: hrdata = {21'h000000, pullupCfg_reg};
         `EMB_OFS_P10DIR: hrdata = {24'h000000, p10Dir_reg};
         `EMB_OFS_ADSEL:  hrdata = {30'h00000000, adSel_reg};
         `EMB_OFS_STATUS: begin
            hrdata[`EMB_ST_HOLD]      = holdActive;
            hrdata[`EMB_ST_BLOCKED]   = port10Blocked;
            hrdata[`EMB_ST_MISUSE]    = misuse;
            hrdata[`EMB_ST_RESETSEEN] = resetSeen_reg;
            hrdata[`EMB_ST_MODE+1:`EMB_ST_MODE] = coreMode;
         end
         default: hrdata = 32'h0000_0000;
      endcase
   end

   // ----------------------------------------------------------------------
   // Pull-ups, port_ten and analog group
   // ----------------------------------------------------------------------
   for (genvar g = 0; g < 11; g++) begin : g_pullup
      if (g < `EMB_LOW_GROUPS) begin : g_off
         assign pullupDrive[g] = 1'b0;
      end else begin : g_on
         assign pullupDrive[g] = pullupCfg_reg[g];
      end
   end

   // Direction and pull-up settings pass unchanged for every analog choice
   assign port10Dir = p10Dir_reg;
   assign port10Blocked = adSel_reg == emb_pkg::ADSEL_PORT0 ||
                          adSel_reg == emb_pkg::ADSEL_PORT2;
   // Flags software that skipped the port_ten setup before group zero/two
   assign misuse = port10Blocked && (p10Dir_reg != 8'h00 || pullupCfg_reg[10]);

   always_ff @(posedge core_clk) begin
      if (reset) begin
         port10PortData <= 8'h00;
         port10KeyLevel <= 8'hff;
      end else if (ce) begin
         port10PortData <= port10Blocked ? 8'h00 : port10Pins;
         port10KeyLevel <= port10Blocked ? 8'hff : port10Pins;
      end
   end

   // ----------------------------------------------------------------------
   // Target reset gate
   // ----------------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (reset) begin
         coreResetReq <= 1'b0;
      end else if (ce) begin
         coreResetReq <= !targetReset_n && coreMode == emb_pkg::MODE_RUN;
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         resetSeen_reg <= 1'b0;
      end else if (ce && !targetReset_n && coreMode == emb_pkg::MODE_RUN) begin
         resetSeen_reg <= 1'b1;
      end
   end

   // ----------------------------------------------------------------------
   // Bus hold
   // ----------------------------------------------------------------------
   emb_hold_delay #(
      .CNT_W (3)
   ) u_hold (
      .core_clk   (core_clk),
      .reset      (reset),
      .ce         (ce),
      .halfTick   (busHalfTick),
      .holdReq_n  (busHoldRequest_n),
      .holdActive (holdActive)
   );

   assign busOe_n = holdActive;

   // ----------------------------------------------------------------------
   // Bus output next state
   // ----------------------------------------------------------------------
   logic [ADDR_W-1:0] addr_next;
   logic              bhe_next;
   logic [DATA_W-1:0] wdata_next;
   logic              dOe_next;
   logic              rd_next;
   logic              wr_next;
   logic              cs_next;
   logic              ale_next;
   logic              rdLow;
   logic              wrLow;

   assign rdLow = accValid && strobePhase && !accWrite;
   assign wrLow = accValid && strobePhase && accWrite;

   always_comb begin
      addr_next  = addrOut;
      bhe_next   = byteHighEnable_n;
      wdata_next = dataOut;
      dOe_next   = 1'b1;
      rd_next    = 1'b1;
      wr_next    = 1'b1;
      cs_next    = 1'b1;
      ale_next   = 1'b0;
      unique case (coreMode)
         emb_pkg::MODE_RUN: begin
            if (accValid) begin
               addr_next = accAddr;
               bhe_next  = accByteHigh_n;
               ale_next  = alePhase;
               unique case (accArea)
                  emb_pkg::AREA_REGS: begin
                     rd_next    = !rdLow;
                     wr_next    = !wrLow;
                     dOe_next   = !accWrite;
                     wdata_next = accWdata;
                  end
                  emb_pkg::AREA_INTERNAL: begin
                     dOe_next = 1'b1;
                  end
                  emb_pkg::AREA_EXTERNAL: begin
                     cs_next    = 1'b0;
                     rd_next    = !rdLow;
                     wr_next    = !wrLow;
                     dOe_next   = !accWrite;
                     wdata_next = accWdata;
                  end
                  default: ;
               endcase
            end
         end
         emb_pkg::MODE_STOPPED: begin
            if (accValid) begin
               addr_next = accAddr;
               bhe_next  = accByteHigh_n;
               ale_next  = alePhase;
               cs_next   = accArea != emb_pkg::AREA_EXTERNAL;
               rd_next   = !rdLow;
            end
         end
         emb_pkg::MODE_STOP, emb_pkg::MODE_WAIT: begin
            cs_next  = chipSelect_n;
            ale_next = 1'b1;
         end
      endcase
   end

   // ----------------------------------------------------------------------
   // Bus output flops
   // ----------------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (reset) begin
         addrOut          <= '0;
         byteHighEnable_n <= 1'b1;
         chipSelect_n     <= 1'b1;
         dataOut          <= '0;
      end else if (ce) begin
         addrOut          <= addr_next;
         byteHighEnable_n <= bhe_next;
         chipSelect_n     <= cs_next;
         dataOut          <= wdata_next;
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         dataOe_n        <= 1'b1;
         readStrobe_n    <= 1'b1;
         writeStrobe_n   <= 1'b1;
         addrLatchStrobe <= 1'b0;
      end else if (ce) begin
         dataOe_n        <= dOe_next;
         readStrobe_n    <= rd_next;
         writeStrobe_n   <= wr_next;
         addrLatchStrobe <= ale_next;
      end
   end

   // ----------------------------------------------------------------------
   // External read capture
   // ----------------------------------------------------------------------
   logic extRead_reg;

   always_ff @(posedge core_clk) begin
      if (reset) begin
         extRead_reg <= 1'b0;
      end else if (ce) begin
         extRead_reg <= coreMode == emb_pkg::MODE_RUN && rdLow &&
                        accArea == emb_pkg::AREA_EXTERNAL;
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         readData      <= '0;
         readDataValid <= 1'b0;
      end else if (ce) begin
         readDataValid <= extRead_reg && !readStrobe_n == 1'b1;
         if (extRead_reg && !readStrobe_n) begin
            readData <= dataIn;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   a_pullup_low_off: assert property (@(posedge core_clk) disable iff (reset)
      pullupDrive[5:0] == 6'h00)
      else $error("low group pull-up driven");

   a_pullup_high_cfg: assert property (@(posedge core_clk) disable iff (reset)
      pullupDrive[10:6] == pullupCfg_reg[10:6])
      else $error("high group pull-up differs from setting");

   a_pullup_readback: assert property (@(posedge core_clk) disable iff (reset)
      (ce && wrPend_reg && phAddr_reg == `EMB_OFS_PULLUP) |=>
         pullupCfg_reg == $past(hwdata[10:0]))
      else $error("pull-up setting did not store written value");

   a_p10_blocked: assert property (@(posedge core_clk) disable iff (reset)
      (ce && port10Blocked) |=> port10PortData == 8'h00 && port10KeyLevel == 8'hff)
      else $error("port_ten input visible while analog group blocks it");

   a_regs_access: assert property (@(posedge core_clk) disable iff (reset)
      (ce && coreMode == emb_pkg::MODE_RUN && accValid && accArea == emb_pkg::AREA_REGS)
         |=> chipSelect_n && addrOut == $past(accAddr) && addrLatchStrobe == $past(alePhase))
      else $error("register area access outputs wrong");

   a_int_quiet: assert property (@(posedge core_clk) disable iff (reset)
      (ce && coreMode == emb_pkg::MODE_RUN && accValid && accArea == emb_pkg::AREA_INTERNAL)
         |=> readStrobe_n && writeStrobe_n && chipSelect_n && dataOe_n)
      else $error("internal access drove strobes or data");

   a_ext_drive: assert property (@(posedge core_clk) disable iff (reset)
      (ce && coreMode == emb_pkg::MODE_RUN && accValid && accArea == emb_pkg::AREA_EXTERNAL)
         |=> !chipSelect_n && addrOut == $past(accAddr) && dataOe_n == $past(!accWrite))
      else $error("external access outputs wrong");

   a_stopped_nowr: assert property (@(posedge core_clk) disable iff (reset)
      (ce && coreMode == emb_pkg::MODE_STOPPED) |=> writeStrobe_n && dataOe_n)
      else $error("write strobe or data driven while stopped");

   a_stop_hold: assert property (@(posedge core_clk) disable iff (reset)
      (ce && coreMode == emb_pkg::MODE_STOP) |=> $stable(addrOut) && $stable(chipSelect_n)
         && readStrobe_n && writeStrobe_n && addrLatchStrobe && dataOe_n)
      else $error("stop mode outputs not held");

   a_wait_hold: assert property (@(posedge core_clk) disable iff (reset)
      (ce && coreMode == emb_pkg::MODE_WAIT) [*2] |=> $stable(byteHighEnable_n)
         && $stable(addrOut) && readStrobe_n && addrLatchStrobe)
      else $error("wait mode outputs not held");

   a_reset_gate: assert property (@(posedge core_clk) disable iff (reset)
      $rose(coreResetReq) |-> $past(coreMode) == emb_pkg::MODE_RUN && !$past(targetReset_n))
      else $error("target reset accepted outside run");

endmodule

// ===== logic/emb_hold_delay.sv
// Delayed entry into bus hold, counted in bus half cycles.
// Assumes halfTick pulses once per half cycle of the emulated bus clock.
`timescale 1ns/100ps
`include "emb_params.svh"
module emb_hold_delay #(
   parameter int CNT_W = 3
) (
   input  wire logic core_clk,
   input  wire logic reset,
   input  wire logic ce,
   input  wire logic halfTick,
   input  wire logic holdReq_n,
   output logic      holdActive
);

   localparam logic [CNT_W-1:0] DELAY = CNT_W'(`EMB_HOLD_DELAY_HALF);

   logic [CNT_W-1:0] halfCnt_reg;
   logic             holdActive_reg;

   // ----------------------------------------------------------------------
   // Half cycle counter
   // ----------------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (reset) begin
         halfCnt_reg <= '0;
      end else if (ce) begin
         if (holdReq_n) begin
            halfCnt_reg <= '0;
         end else if (halfTick && !holdActive_reg) begin
            halfCnt_reg <= halfCnt_reg + CNT_W'(1);
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         holdActive_reg <= 1'b0;
      end else if (ce) begin
         if (holdReq_n) begin
            holdActive_reg <= 1'b0;
         end else if (halfTick && halfCnt_reg == DELAY - CNT_W'(1)) begin
            holdActive_reg <= 1'b1;
         end
      end
   end

   assign holdActive = holdActive_reg;

   a_hold_entry: assert property (@(posedge core_clk) disable iff (reset)
      (ce && halfTick && !holdReq_n && halfCnt_reg == DELAY - CNT_W'(1)) |=> holdActive)
      else $error("hold not entered after delay");

   a_hold_early: assert property (@(posedge core_clk) disable iff (reset)
      $rose(holdActive) |-> $past(halfCnt_reg) == DELAY - CNT_W'(1))
      else $error("hold entered before delay elapsed");

endmodule

// ===== logic/emb_params.svh
// Offsets, field positions, reset values and counts of the emulated bus output block.
// Assumes inclusion by bare name from the block's design files.
//
// Summary of operation
// - Pull-ups of port_zero to port_five never drive, whatever the setting.
// - Pull-ups of port_six to port_ten bit 0 drive as configured.
// - Pull-up setting is fully writable and reads back for every group.
// - Hold request low puts bus pins in hold 2.5 bus cycles late.
// - With analog group zero/two chosen, port_ten gives no port or key input.
// - Analog group port_ten chosen imposes no extra restriction on port_ten.
// - Register area access drives address and data, strobes, ALE; chip select high.
// - Internal memory access drives address and ALE; data floats, strobes high.
// - External access drives all, chip select low, captures read data.
// - Program stopped drives address, select, ALE, read strobe; write high, data floats.
// - Stop mode holds address and select; data floats; strobes and ALE high.
// - Wait mode holds address and select; data floats; strobes and ALE high.
// - Target reset is accepted only while the user program runs.
`ifndef EMB_PARAMS_SVH
`define EMB_PARAMS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define EMB_OFS_PULLUP   8'h00
`define EMB_OFS_P10DIR   8'h04
`define EMB_OFS_ADSEL    8'h08
`define EMB_OFS_STATUS   8'h0c

// ----------------------------------------------------------------------
// Reset values and field positions
// ----------------------------------------------------------------------
`define EMB_PULLUP_RST   11'h000
`define EMB_P10DIR_RST   8'h00
`define EMB_ADSEL_RST    2'h3
`define EMB_ST_HOLD      0
`define EMB_ST_BLOCKED   1
`define EMB_ST_MISUSE    2
`define EMB_ST_RESETSEEN 3
`define EMB_ST_MODE      4
`define EMB_LOW_GROUPS   6

// ----------------------------------------------------------------------
// Timing counts
// ----------------------------------------------------------------------
`define EMB_HOLD_DELAY_HALF 5

`endif

// ===== logic/emb_pkg.sv
// Types of the emulated bus output block.
// Assumes emb_params.svh is included by the modules that need the numbers.
package emb_pkg;

   typedef enum logic [1:0] {
      MODE_RUN,
      MODE_STOPPED,
      MODE_STOP,
      MODE_WAIT
   } emb_mode_e;

   typedef enum logic [1:0] {
      AREA_REGS,
      AREA_INTERNAL,
      AREA_EXTERNAL
   } emb_area_e;

   // Register field encoding, so codes are fixed
   typedef enum logic [1:0] {
      ADSEL_PORT0  = 2'h0,
      ADSEL_PORT2  = 2'h1,
      ADSEL_PORT10 = 2'h2,
      ADSEL_NONE   = 2'h3
   } emb_adsel_e;

endpackage

// ===== sim/emb_target_model.sv
// Target memory on the pod's external bus, sixteen words deep.
// Assumes registered pod strobes, all timed by core_clk.
`timescale 1ns/100ps
module emb_target_model (
   input  wire logic        core_clk,
   input  wire logic [19:0] addrOut,
   input  wire logic        chipSelect_n,
   input  wire logic        readStrobe_n,
   input  wire logic        writeStrobe_n,
   input  wire logic [15:0] dataOut,
   output logic [15:0]      dataIn
);
   logic [15:0] mem [16];
   logic [15:0] lastVal;
   wire         rdSel = !chipSelect_n && !readStrobe_n;
   initial begin
      lastVal = 16'h0000;
      for (int i = 0; i < 16; i++) mem[i] = 16'h0000;
   end
   always @(posedge core_clk) begin
      if (!chipSelect_n && !writeStrobe_n) mem[addrOut[3:0]] <= dataOut;
      if (rdSel) lastVal <= mem[addrOut[3:0]];
   end
   // Released data lines show the inverse of the last word, never a stale copy
   assign dataIn = rdSel ? mem[addrOut[3:0]] : ~lastVal;
endmodule

// ===== sim/test_emulated_mcu_bus_outputs.sv
// Self-checking bench of the pod bus outputs, registers and port_ten gating.
// Assumes emb_pkg compiled first and emb_params.svh on the include path.
`timescale 1ns/100ps
`include "emb_params.svh"
module test_emulated_mcu_bus_outputs;
   logic core_clk = 1'b0, reset = 1'b1, ce = 1'b1, hsel = 1'b1, hwrite = 1'b0;
   logic [1:0]  htrans = 2'h0;
   logic [2:0]  hsize = 3'h2;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
   emb_pkg::emb_mode_e coreMode = emb_pkg::MODE_RUN;
   emb_pkg::emb_area_e accArea = emb_pkg::AREA_INTERNAL;
   logic accValid = 1'b0, accWrite = 1'b0, accByteHigh_n = 1'b1, strobePhase = 1'b0;
   logic alePhase = 1'b0, busHalfTick = 1'b0, busHoldRequest_n = 1'b1, targetReset_n = 1'b1;
   logic [19:0] accAddr = 20'h0, addrOut, pAddr = 20'h0;
   logic [15:0] accWdata = 16'h0, readData, dataOut, dataIn;
   logic [15:0] expMem [16] = '{default: 16'h0000};
   logic hreadyout, hresp, readDataValid, coreResetReq, byteHighEnable_n, dataOe_n;
   logic readStrobe_n, writeStrobe_n, chipSelect_n, addrLatchStrobe, busOe_n;
   logic pBhe = 1'b1, pCs = 1'b1;
   logic [10:0] pullupDrive;
   logic [7:0]  port10Dir, port10Pins = 8'h00, port10PortData, port10KeyLevel;
   int numErrors = 0, checksDone = 0;

   always #12.5 core_clk = ~core_clk;

   emb_bus_out i_emb_bus_out (
      .core_clk, .reset, .ce, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready(hreadyout), .hreadyout, .hresp, .hrdata, .coreMode, .accValid, .accArea,
      .accWrite, .accAddr, .accByteHigh_n, .accWdata, .strobePhase, .alePhase,
      .busHalfTick, .readData, .readDataValid, .coreResetReq, .addrOut, .byteHighEnable_n,
      .dataOut, .dataOe_n, .dataIn, .readStrobe_n, .writeStrobe_n, .chipSelect_n,
      .addrLatchStrobe, .busOe_n, .busHoldRequest_n, .targetReset_n, .pullupDrive,
      .port10Dir, .port10Pins, .port10PortData, .port10KeyLevel);

   emb_target_model i_emb_target_model (
      .core_clk, .addrOut, .chipSelect_n, .readStrobe_n, .writeStrobe_n, .dataOut, .dataIn);

   // ------------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------------
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checksDone++;
      if (got !== exp) begin
         numErrors++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic closeOut();
      $display("Checks %0d errors %0d", checksDone, numErrors);
      if (numErrors == 0 && checksDone > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic waitReady();
      int n;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (hreadyout !== 1'b1 && n < 100);
      if (n >= 100) chk("hreadyout", 1, 0);
   endtask

   task automatic ahbXfer(input logic wr, input logic [31:0] a, input logic [31:0] d,
                          output logic [31:0] rd);
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= wr;
      waitReady();
      htrans <= 2'h0;
      hwdata <= d;
      waitReady();
      rd = hrdata;
      chk("hresp", 0, hresp);
   endtask

   task automatic busStep();
      emb_pkg::emb_mode_e m;
      emb_pkg::emb_area_e ar;
      logic [19:0] a;
      logic [15:0] d;
      logic        b, wr, st, al, hold, ext, run, cs, rdn, wrn, oe;
      m = emb_pkg::emb_mode_e'($urandom_range(3));
      ar = emb_pkg::emb_area_e'($urandom_range(2));
      {a, d, b, wr, st, al} = 40'({$urandom(), $urandom()});
      hold = (m == emb_pkg::MODE_STOP) || (m == emb_pkg::MODE_WAIT);
      ext = (ar != emb_pkg::AREA_INTERNAL);
      run = (m == emb_pkg::MODE_RUN);
      coreMode <= m;
      accArea <= ar;
      accValid <= 1'b1;
      accAddr <= a;
      accWdata <= d;
      accByteHigh_n <= b;
      accWrite <= wr;
      strobePhase <= st;
      alePhase <= al;
      cs = hold ? pCs : (ar != emb_pkg::AREA_EXTERNAL);
      rdn = hold || !(st && !wr && (ext || m == emb_pkg::MODE_STOPPED));
      wrn = hold || !(st && wr && ext && run);
      oe = hold || !(wr && ext && run);
      if (hold) begin
         a = pAddr;
         b = pBhe;
         al = 1'b1;
      end
      repeat (2) @(posedge core_clk);
      chk("busPins", {a, b, cs, wrn, oe, al}, {addrOut, byteHighEnable_n, chipSelect_n,
          writeStrobe_n, dataOe_n, addrLatchStrobe});
      chk("readStrobe", rdn, readStrobe_n);
      if (!oe) chk("dataOut", d, dataOut);
      if (run && ar == emb_pkg::AREA_EXTERNAL && st) begin
         if (wr) expMem[a[3:0]] = d;
         @(posedge core_clk);
         if (!wr) chk("readData", expMem[a[3:0]], readData);
         chk("readValid", 32'(!wr), readDataValid);
      end
      pAddr = a;
      pBhe = b;
      pCs = cs;
   endtask

   // ------------------------------------------------------------------
   // Main sequence and watchdog
   // ------------------------------------------------------------------
   initial begin
      #125000;
      numErrors++;
      closeOut();
   end

   initial begin
      logic [31:0] r, rd;
      void'($urandom(84076));
      repeat (4) @(posedge core_clk);
      reset <= 1'b0;
      @(posedge core_clk);
      for (int i = 0; i < 60; i++) busStep();
      accValid <= 1'b0;
      ahbXfer(1'b0, `EMB_OFS_ADSEL, 0, rd);
      chk("adselReset", 32'h3, rd);
      for (int i = 0; i < 3; i++) begin
         r = $urandom() & 32'h7ff;
         ahbXfer(1'b1, `EMB_OFS_PULLUP, r, rd);
         ahbXfer(1'b0, `EMB_OFS_PULLUP, 0, rd);
         chk("pullupCfg", r, rd);
         chk("pullupDrive", r & 32'h7c0, pullupDrive);
      end
      ahbXfer(1'b1, 32'h10, 32'hffff, rd);
      ahbXfer(1'b0, 32'h10, 0, rd);
      chk("unmapped", 0, rd);
      for (int g = 0; g < 4; g++) begin
         r = $urandom();
         ahbXfer(1'b1, `EMB_OFS_P10DIR, (g < 2) ? 32'h0 : 32'(r[7:0]), rd);
         ahbXfer(1'b1, `EMB_OFS_PULLUP, (g < 2) ? 32'h0 : 32'h400, rd);
         ahbXfer(1'b1, `EMB_OFS_ADSEL, 32'(g), rd);
         port10Pins <= r[15:8];
         repeat (3) @(posedge core_clk);
         chk("portData", (g < 2) ? 32'h0 : 32'(r[15:8]), port10PortData);
         chk("keyLevel", (g < 2) ? 32'hff : 32'(r[15:8]), port10KeyLevel);
         chk("dirPullup", (g < 2) ? 32'h0 : {r[7:0], 1'b1}, {port10Dir, pullupDrive[10]});
         ahbXfer(1'b0, `EMB_OFS_STATUS, 0, rd);
         chk("status", {coreMode, 2'b00, (g < 2), 1'b0}, rd);
      end
      // Group zero with port_ten pull-up still set must raise the misuse flag
      ahbXfer(1'b1, `EMB_OFS_ADSEL, 32'h0, rd);
      busHoldRequest_n <= 1'b0;
      @(posedge core_clk);
      for (int t = 1; t <= 5; t++) begin
         @(posedge core_clk);
         if (t == 5) chk("holdEarly", 0, busOe_n);
         busHalfTick <= 1'b1;
         @(posedge core_clk);
         busHalfTick <= 1'b0;
      end
      repeat (2) @(posedge core_clk);
      chk("holdOn", 1, busOe_n);
      ahbXfer(1'b0, `EMB_OFS_STATUS, 0, rd);
      chk("statusHold", {coreMode, 4'h7}, rd);
      busHoldRequest_n <= 1'b1;
      repeat (3) @(posedge core_clk);
      chk("holdOff", 0, busOe_n);
      coreMode <= emb_pkg::MODE_STOPPED;
      targetReset_n <= 1'b0;
      repeat (3) @(posedge core_clk);
      chk("resetStopped", 0, coreResetReq);
      coreMode <= emb_pkg::MODE_RUN;
      repeat (3) @(posedge core_clk);
      chk("resetRun", 1, coreResetReq);
      ahbXfer(1'b0, `EMB_OFS_STATUS, 0, rd);
      chk("statusEnd", 32'he, rd);
      ce <= 1'b0;
      targetReset_n <= 1'b1;
      repeat (3) @(posedge core_clk);
      chk("ceFreeze", 1, coreResetReq);
      ce <= 1'b1;
      repeat (2) @(posedge core_clk);
      chk("ceRun", 0, coreResetReq);
      closeOut();
   end
endmodule
